// ---- verilog/lsc_consts.vh ----
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH
// ------------------------------------------------------------
// register byte offsets (word aligned)
// ------------------------------------------------------------
`define LSC_OFS_CTRL     8'h00
`define LSC_OFS_MASK     8'h04
`define LSC_OFS_FLAG     8'h08
`define LSC_OFS_IRQCFG   8'h0C
`define LSC_OFS_THRESH   8'h10
`define LSC_OFS_DCTERM   8'h14
`define LSC_OFS_STATUS   8'h18
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LSC_CTRL_OFFHOOK    0
`define LSC_CTRL_RESISTOR_CAL_DISABLE      1
`define LSC_CTRL_CCALD      2
`define LSC_CTRL_TIPOPEN    3
`define LSC_CTRL_RINGGND    4
`define LSC_CTRL_SETTLE_LO  5
`define LSC_IRQ_POL         6
`define LSC_IRQ_OE          7
`define LSC_TH_ENABLE       9
`define LSC_TH_SRC          10
`define LSC_TH_FLAG         11
`define LSC_TH_DIR          12
`define LSC_FLAG_POL        0
`define LSC_FLAG_TIPGND     1
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LSC_CTRL_RST    8'h50
`define LSC_IRQCFG_RST  8'h00
// ------------------------------------------------------------
// timing: figures in microseconds, clock in MHz
// ------------------------------------------------------------
`define LSC_CLK_MHZ      100
`define LSC_LAT_US       250
`define LSC_SET0_US      8000
`define LSC_SET1_US      64000
`define LSC_SET2_US      128000
`define LSC_SET3_US      512000
`define LSC_RCAL_US      17000
`define LSC_CCAL_US      256000
`define LSC_LAT_CYC      (`LSC_LAT_US * `LSC_CLK_MHZ)
`define LSC_SET0_CYC     (`LSC_SET0_US * `LSC_CLK_MHZ)
`define LSC_SET1_CYC     (`LSC_SET1_US * `LSC_CLK_MHZ)
`define LSC_SET2_CYC     (`LSC_SET2_US * `LSC_CLK_MHZ)
`define LSC_SET3_CYC     (`LSC_SET3_US * `LSC_CLK_MHZ)
`define LSC_RCAL_CYC     (`LSC_RCAL_US * `LSC_CLK_MHZ)
`define LSC_CCAL_CYC     (`LSC_CCAL_US * `LSC_CLK_MHZ)
`endif

// ---- verilog/lsc_line_ctrl.v ----
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "lsc_consts.vh"

// Summary of operation
// - offhook bit drives hookswitch, termination
// - offhook reaches line side after latency
// - settling count chosen by two-bit field
// - resistor calibration follows unless disabled
// - converter calibration follows unless disabled
// - line data held off until settled
// - detect status follows tip current sense
// - sticky tip flag, cleared by zero write
// - irq enable turns shared pin to irq
// - polarity bit selects level, open drain
// - nine enables gate sources onto pin
// - sticky flags polled and cleared by software
// - threshold compares voltage or fine current
// - direction bit picks rise or fall
// - comparison uses magnitude of signed value
// - slope bit selects 800 ohm dc slope
// - limit bit selects current limiting mode
// - min current and dc voltage fields
// - basic unit maps all ac codes but 0, 3, 4 and F to zero
// - sign change of voltage sets polarity flag, rich unit only
module lsc_line_ctrl #(
  parameter LAT_CYC  = `LSC_LAT_CYC,
  parameter SET0_CYC = `LSC_SET0_CYC,
  parameter SET1_CYC = `LSC_SET1_CYC,
  parameter SET2_CYC = `LSC_SET2_CYC,
  parameter SET3_CYC = `LSC_SET3_CYC,
  parameter RCAL_CYC = `LSC_RCAL_CYC,
  parameter CCAL_CYC = `LSC_CCAL_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // line side
  input  wire        rich_unit_i,
  input  wire        tip_current_i,
  input  wire [7:0]  line_voltage_reading_i,
  input  wire [7:0]  fine_loop_current_reading_i,
  output reg         line_offhook_o,
  output reg         resistor_cal_o,
  output reg         converter_cal_o,
  output reg         line_data_enable_o,
  output wire        tip_relay_open_o,
  output wire        ring_ground_control_o,
  output wire        dc_slope_select_o,
  output wire        current_limit_mode_o,
  output wire [1:0]  min_loop_current_select_o,
  output wire [1:0]  dc_voltage_adjust_o,
  output reg  [3:0]  ac_termination_select_o,
  // shared analog/irq pin, open drain in irq mode
  output wire        analog_or_irq_pin_o,
  output wire        analog_or_irq_pin_oe_o,
  output wire        analog_out_enable_o
);

  // ----------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------
  localparam [2:0] ST_ONHOOK = 3'h0;
  localparam [2:0] ST_LAT    = 3'h1;
  localparam [2:0] ST_SETTLE = 3'h2;
  localparam [2:0] ST_RCAL   = 3'h3;
  localparam [2:0] ST_CCAL   = 3'h4;
  localparam [2:0] ST_READY  = 3'h5;

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  reg  [7:0]  ctrl_r;        // hook, cal disables, relays, settle
  reg  [7:0]  mask_r;        // interrupt enables
  reg  [7:0]  flag_r;        // sticky interrupt flags
  reg  [7:0]  irqcfg_r;      // pin mode and polarity
  reg  [7:0]  th_value_r;    // threshold magnitude
  reg         th_en_r;       // threshold interrupt enable
  reg         th_src_r;      // 0 voltage, 1 fine current
  reg         th_dir_r;      // 0 rise above, 1 fall below
  reg         th_flag_r;     // sticky threshold flag
  reg  [9:0]  dcterm_r;      // dc and ac termination fields
  reg  [2:0]  state_r;       // sequencer state
  reg  [26:0] cnt_r;         // phase down-counter
  // synchronisers for pin-side inputs
  reg  [1:0]  tip_s_r;
  reg  [7:0]  lv_s1_r;
  reg  [7:0]  lv_s2_r;
  reg  [7:0]  lc_s1_r;
  reg  [7:0]  lc_s2_r;
  reg  [1:0]  rich_s_r;
  reg         tip_prev_r;    // for current-onset edge
  reg         sign_prev_r;   // for voltage polarity edge
  reg         above_prev_r;  // last comparator result

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // magnitude of a signed 8-bit reading, saturated at 127
  function [7:0] mag8;
    input [7:0] v;
    begin
      if (v[7]) begin
        mag8 = (v == 8'h80) ? 8'h7F : (~v + 8'h01);
      end else begin
        mag8 = v;
      end
    end
  endfunction

  // settle-count lookup
  function [26:0] settle_cyc;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    settle_cyc = SET0_CYC[26:0];
        2'h1:    settle_cyc = SET1_CYC[26:0];
        2'h2:    settle_cyc = SET2_CYC[26:0];
        default: settle_cyc = SET3_CYC[26:0];
      endcase
    end
  endfunction

  // ----------------------------------------------------------
  // decode and comparator
  // ----------------------------------------------------------
  wire        wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr      = wb_req & wb_we_i & wb_sel_i[0] & ce_i;
  wire        wr_ctrl    = wb_wr & (wb_adr_i == `LSC_OFS_CTRL);
  wire        wr_mask    = wb_wr & (wb_adr_i == `LSC_OFS_MASK);
  wire        wr_flag    = wb_wr & (wb_adr_i == `LSC_OFS_FLAG);
  wire        wr_irqcfg  = wb_wr & (wb_adr_i == `LSC_OFS_IRQCFG);
  wire        wr_thresh  = wb_wr & (wb_adr_i == `LSC_OFS_THRESH);
  wire        wr_th_hi   = wr_thresh & wb_sel_i[1];
  wire        wr_dcterm  = wb_wr & (wb_adr_i == `LSC_OFS_DCTERM);
  wire        tip_det    = tip_s_r[1];
  wire        tip_rise   = tip_det & ~tip_prev_r;
  wire        sign_chg   = lv_s2_r[7] ^ sign_prev_r;
  wire [7:0]  meas_mag   = mag8(th_src_r ? lc_s2_r : lv_s2_r);
  wire        above      = meas_mag > th_value_r;
  // crossing in the chosen direction, rich unit only
  wire        th_hit     = rich_s_r[1] &
                           (th_dir_r ? (above_prev_r & ~above)
                                     : (~above_prev_r & above));
  wire [1:0]  settle_sel = ctrl_r[`LSC_CTRL_SETTLE_LO +: 2];

  // ----------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------
  wire irq_any = (|(flag_r & mask_r)) | (th_flag_r & th_en_r);
  wire irq_oe  = irqcfg_r[`LSC_IRQ_OE];
  wire irq_pol = irqcfg_r[`LSC_IRQ_POL];
  // open drain: drive the active level only while a source is pending,
  // released otherwise so the board resistor holds the idle level
  assign analog_or_irq_pin_o    = irq_pol;
  assign analog_or_irq_pin_oe_o = irq_oe & irq_any;
  assign analog_out_enable_o    = ~irq_oe;

  // ----------------------------------------------------------
  // relay and termination outputs
  // ----------------------------------------------------------
  assign tip_relay_open_o          = ctrl_r[`LSC_CTRL_TIPOPEN];
  assign ring_ground_control_o     = ctrl_r[`LSC_CTRL_RINGGND];
  assign dc_slope_select_o         = dcterm_r[0];
  assign current_limit_mode_o      = dcterm_r[1];
  assign min_loop_current_select_o = dcterm_r[3:2];
  assign dc_voltage_adjust_o       = dcterm_r[5:4];

  // basic unit honours only four ac codes
  always @* begin
    ac_termination_select_o = dcterm_r[9:6];
    if (!rich_s_r[1]) begin
      case (dcterm_r[9:6])
        4'h0, 4'h3, 4'h4, 4'hF: ac_termination_select_o = dcterm_r[9:6];
        default:                ac_termination_select_o = 4'h0;
      endcase
    end
  end

  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      tip_s_r  <= 2'h0;
      rich_s_r <= 2'h0;
      lv_s1_r  <= 8'h00;
      lv_s2_r  <= 8'h00;
      lc_s1_r  <= 8'h00;
      lc_s2_r  <= 8'h00;
    end else if (ce_i) begin
      tip_s_r  <= {tip_s_r[0], tip_current_i};
      rich_s_r <= {rich_s_r[0], rich_unit_i};
      lv_s1_r  <= line_voltage_reading_i;
      lv_s2_r  <= lv_s1_r;
      lc_s1_r  <= fine_loop_current_reading_i;
      lc_s2_r  <= lc_s1_r;
    end
  end

  // ----------------------------------------------------------
  // software registers and sticky flags
  // ----------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r       <= `LSC_CTRL_RST;
      mask_r       <= 8'h00;
      flag_r       <= 8'h00;
      irqcfg_r     <= `LSC_IRQCFG_RST;
      th_value_r   <= 8'h00;
      th_en_r      <= 1'b0;
      th_src_r     <= 1'b0;
      th_dir_r     <= 1'b0;
      th_flag_r    <= 1'b0;
      dcterm_r     <= 10'h000;
      tip_prev_r   <= 1'b0;
      sign_prev_r  <= 1'b0;
      above_prev_r <= 1'b0;
    end else if (ce_i) begin
      tip_prev_r   <= tip_det;
      sign_prev_r  <= lv_s2_r[7];
      above_prev_r <= above;
      if (wr_ctrl)   ctrl_r     <= wb_dat_i[7:0];
      if (wr_mask)   mask_r     <= wb_dat_i[7:0];
      if (wr_irqcfg) irqcfg_r   <= wb_dat_i[7:0];
      if (wr_thresh) th_value_r <= wb_dat_i[7:0];
      if (wr_th_hi) begin
        th_en_r  <= wb_dat_i[`LSC_TH_ENABLE];
        th_src_r <= wb_dat_i[`LSC_TH_SRC];
        th_dir_r <= wb_dat_i[`LSC_TH_DIR];
      end
      if (wr_dcterm) dcterm_r <= wb_dat_i[9:0];
      // writing zero clears a flag; a same-cycle event wins
      flag_r[`LSC_FLAG_POL] <= (flag_r[`LSC_FLAG_POL] &
                                ~(wr_flag & ~wb_dat_i[`LSC_FLAG_POL])) |
                               (sign_chg & rich_s_r[1]);
      flag_r[`LSC_FLAG_TIPGND] <= (flag_r[`LSC_FLAG_TIPGND] &
                                   ~(wr_flag & ~wb_dat_i[`LSC_FLAG_TIPGND])) |
                                  tip_rise;
      // remaining sources live elsewhere; bits only clear here
      if (wr_flag) flag_r[7:2] <= flag_r[7:2] & wb_dat_i[7:2];
      th_flag_r <= (th_flag_r & ~(wr_th_hi & ~wb_dat_i[`LSC_TH_FLAG])) |
                   th_hit;
    end
  end

  // ----------------------------------------------------------
  // off-hook sequencer
  // ----------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r            <= ST_ONHOOK;
      cnt_r              <= 27'h0000000;
      line_offhook_o     <= 1'b0;
      resistor_cal_o     <= 1'b0;
      converter_cal_o    <= 1'b0;
      line_data_enable_o <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_r[`LSC_CTRL_OFFHOOK]) begin
        // on-hook: no loop current, abandon any phase
        state_r            <= ST_ONHOOK;
        line_offhook_o     <= 1'b0;
        resistor_cal_o     <= 1'b0;
        converter_cal_o    <= 1'b0;
        line_data_enable_o <= 1'b0;
      end else begin
        case (state_r)
          ST_ONHOOK: begin
            state_r <= ST_LAT;
            cnt_r   <= LAT_CYC[26:0] - 27'h1;
          end
          ST_LAT: begin
            if (cnt_r == 27'h0) begin
              line_offhook_o <= 1'b1;
              state_r        <= ST_SETTLE;
              cnt_r          <= settle_cyc(settle_sel) - 27'h1;
            end else cnt_r <= cnt_r - 27'h1;
          end
          ST_SETTLE: begin
            if (cnt_r == 27'h0) begin
              line_data_enable_o <= 1'b1;
              if (!ctrl_r[`LSC_CTRL_RESISTOR_CAL_DISABLE]) begin
                state_r        <= ST_RCAL;
                resistor_cal_o <= 1'b1;
                cnt_r          <= RCAL_CYC[26:0] - 27'h1;
              end else if (!ctrl_r[`LSC_CTRL_CCALD]) begin
                state_r         <= ST_CCAL;
                converter_cal_o <= 1'b1;
                cnt_r           <= CCAL_CYC[26:0] - 27'h1;
              end else begin
                state_r <= ST_READY;
              end
            end else cnt_r <= cnt_r - 27'h1;
          end
          ST_RCAL: begin
            if (cnt_r == 27'h0) begin
              resistor_cal_o <= 1'b0;
              if (!ctrl_r[`LSC_CTRL_CCALD]) begin
                state_r         <= ST_CCAL;
                converter_cal_o <= 1'b1;
                cnt_r           <= CCAL_CYC[26:0] - 27'h1;
              end else begin
                state_r <= ST_READY;
              end
            end else cnt_r <= cnt_r - 27'h1;
          end
          ST_CCAL: begin
            if (cnt_r == 27'h0) begin
              converter_cal_o <= 1'b0;
              state_r         <= ST_READY;
            end else cnt_r <= cnt_r - 27'h1;
          end
          ST_READY: state_r <= ST_READY;   // hold until on-hook
          default:  state_r <= ST_ONHOOK;  // stray code restarts cleanly
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // wishbone answer: one wait-free ack, read data registered
  // ----------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        case (wb_adr_i)
          `LSC_OFS_CTRL:   wb_dat_o <= {24'h000000, ctrl_r};
          `LSC_OFS_MASK:   wb_dat_o <= {24'h000000, mask_r};
          `LSC_OFS_FLAG:   wb_dat_o <= {24'h000000, flag_r};
          `LSC_OFS_IRQCFG: wb_dat_o <= {24'h000000, irqcfg_r};
          `LSC_OFS_THRESH: wb_dat_o <= {19'h00000, th_dir_r, th_flag_r, th_src_r,
                                        th_en_r, 1'b0, th_value_r};
          `LSC_OFS_DCTERM: wb_dat_o <= {22'h000000, dcterm_r};
          `LSC_OFS_STATUS: wb_dat_o <= {24'h000000, 1'b0, state_r, irq_any,
                                        line_data_enable_o, line_offhook_o,
                                        tip_det};
          default:         wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ---- dv/lsc_line_ctrl_props.sv ----
`timescale 1ns/100ps
module lsc_line_ctrl_props #(
  parameter LAT_CYC = 10
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        ce_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        rich_unit_i,
  input wire        line_offhook_o,
  input wire        resistor_cal_o,
  input wire        converter_cal_o,
  input wire        line_data_enable_o,
  input wire        tip_relay_open_o,
  input wire        ring_ground_control_o,
  input wire [3:0]  ac_termination_select_o,
  input wire        analog_or_irq_pin_o,
  input wire        analog_or_irq_pin_oe_o,
  input wire        analog_out_enable_o
);
  // ------
  // shadow of control registers
  // ------
  reg  [7:0] ctrl_r;  // control byte as last written
  reg  [7:0] irq_r;   // irq config byte
  integer    hc_r;    // cycles since offhook requested
  wire       take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  // writes land on the take edge, as in the design
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= 8'h50;
      irq_r  <= 8'h00;
    end else if (take && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == 8'h00) ctrl_r <= wb_dat_i[7:0];
      if (wb_adr_i == 8'h0C) irq_r <= wb_dat_i[7:0];
    end
  end
  // saturating, so a long off-hook never wraps
  always @(posedge clk_i) begin
    if (rst_i || !ctrl_r[0]) hc_r <= 0;
    else if (hc_r < LAT_CYC + 8) hc_r <= hc_r + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------
  // properties
  // ------
  property p_onhook;
    !ctrl_r[0] [*2] |-> !line_offhook_o && !line_data_enable_o;
  endproperty
  a_onhook: assert property (p_onhook) else $error("line held without request");
  property p_lat;
    $rose(line_offhook_o) |-> hc_r >= LAT_CYC - 1 && hc_r <= LAT_CYC + 3;
  endproperty
  a_lat: assert property (p_lat) else $error("offhook latency wrong");
  property p_hold;
    $rose(line_data_enable_o) |-> $past(line_offhook_o, 3);
  endproperty
  a_hold: assert property (p_hold) else $error("data enabled before settle");
  property p_rcal;
    $rose(resistor_cal_o) |-> !ctrl_r[1] && line_offhook_o;
  endproperty
  a_rcal: assert property (p_rcal) else $error("resistor cal out of turn");
  property p_ccal;
    $rose(converter_cal_o) |-> !ctrl_r[2] && (ctrl_r[1] || $past(resistor_cal_o));
  endproperty
  a_ccal: assert property (p_ccal) else $error("converter cal out of turn");
  property p_excl;
    !(resistor_cal_o && converter_cal_o);
  endproperty
  a_excl: assert property (p_excl) else $error("calibrations overlap");
  property p_relay;
    tip_relay_open_o == ctrl_r[3] && ring_ground_control_o == ctrl_r[4];
  endproperty
  a_relay: assert property (p_relay) else $error("relay outputs wrong");
  property p_irqmode;
    analog_out_enable_o == !irq_r[7] && (!analog_or_irq_pin_oe_o || irq_r[7]);
  endproperty
  a_irqmode: assert property (p_irqmode) else $error("shared pin mode wrong");
  property p_odrain;
    analog_or_irq_pin_oe_o |-> analog_or_irq_pin_o == irq_r[6];
  endproperty
  a_odrain: assert property (p_odrain) else $error("pin driven at wrong level");
  property p_ac;
    !rich_unit_i [*3] |-> ac_termination_select_o inside {4'h0, 4'h3, 4'h4, 4'hF};
  endproperty
  a_ac: assert property (p_ac) else $error("ac code not honoured");
  property p_ack;
    take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");
endmodule
bind lsc_line_ctrl lsc_line_ctrl_props #(.LAT_CYC(LAT_CYC)) u_props (.*);

// ---- dv/lsc_line_model.sv ----
`timescale 1ns/100ps
// ------
// line side and pin resistor
// ------
module lsc_line_model (
  input  wire        clk_i,
  input  wire        pin_i,
  input  wire        pin_oe_i,
  output logic       tip_o,
  output logic [7:0] volt_o,
  output logic [7:0] cur_o,
  output logic       rich_o,
  output wire        pin_lvl_o
);
  initial begin
    tip_o  = 1'b0;
    volt_o = 8'h0A;
    cur_o  = 8'h05;
    rich_o = 1'b0;
  end
  // new line conditions land just after an edge
  task drive(input logic t, input logic [7:0] v, input logic [7:0] c, input logic r);
    @(posedge clk_i);
    tip_o  <= t;
    volt_o <= v;
    cur_o  <= c;
    rich_o <= r;
  endtask
  // open drain pin: released, the resistor holds the inactive level
  assign pin_lvl_o = pin_oe_i ? pin_i : ~pin_i;
endmodule

// ---- dv/lsc_line_ctrl_bench.sv ----
`timescale 1ns/100ps
module lsc_line_ctrl_bench;
  localparam LAT = 10;
  localparam RCAL = 5;
  localparam CCAL = 7;
  logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pin_lvl;
  logic [7:0]  wb_adr_i, line_voltage_reading_i, fine_loop_current_reading_i;
  logic [3:0]  wb_sel_i, ac_termination_select_o;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        rich_unit_i, tip_current_i, line_offhook_o, resistor_cal_o, converter_cal_o;
  logic        line_data_enable_o, tip_relay_open_o, ring_ground_control_o, dc_slope_select_o;
  logic        current_limit_mode_o, analog_or_irq_pin_o, analog_or_irq_pin_oe_o;
  logic        analog_out_enable_o;
  logic [1:0]  min_loop_current_select_o, dc_voltage_adjust_o;
  int          fail_count, tests_run;
  int          set_c [4] = '{4, 6, 8, 12};  // shortened settle counts
  lsc_line_ctrl #(.LAT_CYC(LAT), .SET0_CYC(4), .SET1_CYC(6), .SET2_CYC(8),
    .SET3_CYC(12), .RCAL_CYC(RCAL), .CCAL_CYC(CCAL)) u_dut (.*);
  lsc_line_model u_line (.clk_i(clk_i), .pin_i(analog_or_irq_pin_o),
    .pin_oe_i(analog_or_irq_pin_oe_o), .tip_o(tip_current_i),
    .volt_o(line_voltage_reading_i), .cur_o(fine_loop_current_reading_i),
    .rich_o(rich_unit_i), .pin_lvl_o(pin_lvl));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ------
  // shared tasks
  // ------
  task check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // classic cycle: hold until ack, release for one cycle
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    check(n, 2);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(q & m, e);
  endtask
  task stop_test;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task t_reset;
    rd(8'h00, 32'hFF, 32'h50);
    rd(8'h0C, 32'hFF, 32'h00);
    wb(1'b1, 8'h1C, 32'hFF);
    rd(8'h1C, 32'hFFFFFFFF, 32'h0);
    @(negedge clk_i);
    check({ring_ground_control_o, analog_out_enable_o}, 2'b11);
  endtask
  // one off-hook run, phases timed at the pins
  task t_seq(input int s, input logic rc, input logic cc);
    int t, toh, tde, nr, nc;
    wb(1'b1, 8'h00, {25'h0, s[1:0], 2'b10, cc, rc, 1'b1});
    toh = -1;
    tde = -1;
    nr = 0;
    nc = 0;
    for (t = 0; t < 80; t++) begin
      @(negedge clk_i);
      if (line_offhook_o === 1'b1 && toh < 0) toh = t;
      if (line_data_enable_o === 1'b1 && tde < 0) tde = t;
      nr += int'(resistor_cal_o === 1'b1);
      nc += int'(converter_cal_o === 1'b1);
    end
    check(toh >= LAT - 3 && toh <= LAT + 1, 1'b1);
    check(tde - toh >= set_c[s] - 1 && tde - toh <= set_c[s] + 1, 1'b1);
    check(nr, rc ? 0 : RCAL);
    check(nc, cc ? 0 : CCAL);
    wb(1'b1, 8'h00, 32'h10);
    @(negedge clk_i);
    check({line_offhook_o, line_data_enable_o}, 2'b00);
  endtask
  task t_tip;
    wb(1'b1, 8'h00, 32'h00); // relay closed, ring ground released
    @(negedge clk_i);
    check({tip_relay_open_o, ring_ground_control_o}, 2'b00);
    wb(1'b1, 8'h04, 32'h02);
    wb(1'b1, 8'h0C, 32'h80);
    u_line.drive(1'b1, 8'h0A, 8'h05, 1'b0);
    repeat (5) @(negedge clk_i);
    rd(8'h18, 32'h1, 32'h1);
    rd(8'h08, 32'h3, 32'h2);
    check(pin_lvl, 1'b0);
    u_line.drive(1'b0, 8'h0A, 8'h05, 1'b0);
    repeat (5) @(negedge clk_i);
    rd(8'h18, 32'h1, 32'h0);
    check(pin_lvl, 1'b0);
    wb(1'b1, 8'h0C, 32'hC0);
    @(negedge clk_i);
    check(pin_lvl, 1'b1);
    wb(1'b1, 8'h08, 32'h00);
    rd(8'h08, 32'h3, 32'h0);
    check(pin_lvl, 1'b0);
    wb(1'b1, 8'h0C, 32'h00);
    @(negedge clk_i);
    check({analog_out_enable_o, analog_or_irq_pin_oe_o}, 2'b10);
    wb(1'b1, 8'h00, 32'h10); // back to idle
  endtask
  // sign change flag, masked then unmasked
  task t_pol;
    u_line.drive(1'b0, 8'h0A, 8'h05, 1'b1);
    wb(1'b1, 8'h04, 32'h00);
    wb(1'b1, 8'h0C, 32'h80);
    wb(1'b1, 8'h08, 32'h00);
    u_line.drive(1'b0, 8'hF6, 8'h05, 1'b1);
    repeat (5) @(negedge clk_i);
    rd(8'h08, 32'h1, 32'h1);
    check(pin_lvl, 1'b1);
    wb(1'b1, 8'h04, 32'h01);
    @(negedge clk_i);
    check(pin_lvl, 1'b0);
    wb(1'b1, 8'h08, 32'h00);
    rd(8'h08, 32'h1, 32'h0);
    check(pin_lvl, 1'b1);
    wb(1'b1, 8'h04, 32'h00);
  endtask
  // threshold 20 on magnitude, both sources and directions
  task t_thr;
    wb(1'b1, 8'h10, 32'h0614);
    u_line.drive(1'b0, 8'hF6, 8'hE7, 1'b1);
    repeat (5) @(negedge clk_i);
    rd(8'h10, 32'h800, 32'h800);
    check(pin_lvl, 1'b0);
    wb(1'b1, 8'h10, 32'h1614);
    rd(8'h10, 32'h800, 32'h0);
    u_line.drive(1'b0, 8'hF6, 8'h05, 1'b1);
    repeat (5) @(negedge clk_i);
    rd(8'h10, 32'h800, 32'h800);
    wb(1'b1, 8'h10, 32'h0214);
    u_line.drive(1'b0, 8'hE2, 8'h05, 1'b1);
    repeat (5) @(negedge clk_i);
    rd(8'h10, 32'h800, 32'h800);
    wb(1'b1, 8'h10, 32'h0);
  endtask
  // every ac code with both units, dc fields alongside
  task t_dc;
    logic [4:0] c;
    for (int r = 0; r < 2; r++) begin
      u_line.drive(1'b0, 8'h0A, 8'h05, r[0]);
      repeat (4) @(negedge clk_i);
      for (c = 0; c < 16; c++) begin
        wb(1'b1, 8'h14, {22'h0, c[3:0], c[3:2], c[2:1], ~c[0], c[0]});
        @(negedge clk_i);
        check(ac_termination_select_o, (r == 1 || c inside {0, 3, 4, 15}) ? c[3:0] : 4'h0);
        check({dc_slope_select_o, current_limit_mode_o, min_loop_current_select_o,
          dc_voltage_adjust_o}, {c[0], ~c[0], c[2:1], c[3:2]});
      end
    end
  endtask
  initial begin
    #200000;
    fail_count++;
    stop_test;
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    fail_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_seq(0, 1'b0, 1'b0); // calibrations kept enabled
    t_seq(1, 1'b1, 1'b0);
    t_seq(2, 1'b0, 1'b1);
    t_seq(3, 1'b1, 1'b1);
    t_tip;
    t_pol;
    t_thr;
    t_dc;
    stop_test;
  end
endmodule
